//--- dsg_top.sv
`timescale 1ns/1ps
`include "dsg_regs.svh"
module dsg_top #(
  parameter logic [10:0] OV_LVL_LO = 11'h19a,
  parameter logic [10:0] OV_LVL_HI = 11'h334,
  parameter logic [15:0] DTIME_RST = 16'h03e8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [10:0] bus_volt,
  output logic [15:0] out_freq,
  output logic ramp_paused,
  output logic brake_en,
  output logic bus_overvoltage_fault,
  output logic irq
);
  function automatic logic [31:0] f_strb(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [10:0] f_stall_lvl(input logic hv, input logic [10:0] vin);
    if (!hv) begin
      return `DSG_LVL_LO;
    end else if (vin >= `DSG_VIN_SPLIT) begin
      return `DSG_LVL_HI;
    end else begin
      return `DSG_LVL_HI_RED;
    end
  endfunction

  // bus write/read channel state
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  // block registers
  logic [4:0] ctrl_q;
  logic [10:0] vin_q;
  logic [15:0] dtime_q, freq_q, per_q;
  logic [2:0] sts_q, mask_q;
  logic irq_q, fault_q, brake_q;
  logic [10:0] bus_m_q, bus_s_q;
  dsg_pkg::dsg_state_t st_q, st_d;

  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire rd_go = arvalid && arready;
  wire wr_ctrl = wr_go && waddr_q == `DSG_OFF_CTRL;
  wire wr_vin = wr_go && waddr_q == `DSG_OFF_VIN;
  wire wr_dtime = wr_go && waddr_q == `DSG_OFF_DTIME;
  wire wr_freq = wr_go && waddr_q == `DSG_OFF_FREQ;
  wire wr_mask = wr_go && waddr_q == `DSG_OFF_MASK;
  wire wr_ok = waddr_q == `DSG_OFF_CTRL || waddr_q == `DSG_OFF_VIN ||
               waddr_q == `DSG_OFF_DTIME || waddr_q == `DSG_OFF_FREQ ||
               waddr_q == `DSG_OFF_STS || waddr_q == `DSG_OFF_MASK ||
               waddr_q == `DSG_OFF_LIVE;
  wire rd_sts = rd_go && araddr == `DSG_OFF_STS;

  wire [31:0] wv_ctrl = f_strb({27'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] wv_vin = f_strb({21'h0, vin_q}, wdata_q, wstrb_q);
  wire [31:0] wv_dtime = f_strb({16'h0, dtime_q}, wdata_q, wstrb_q);
  wire [31:0] wv_freq = f_strb({16'h0, freq_q}, wdata_q, wstrb_q);
  wire [31:0] wv_mask = f_strb({29'h0, mask_q}, wdata_q, wstrb_q);

  // parameters are only changed while stopped
  wire active = st_q == dsg_pkg::dsg_st_ramp || st_q == dsg_pkg::dsg_st_pause;
  wire run = ctrl_q[`DSG_CTRL_RUN];
  wire hv_class = ctrl_q[`DSG_CTRL_HV];
  wire vec_ctrl = ctrl_q[`DSG_CTRL_VEC];
  wire [1:0] sel_mode = ctrl_q[`DSG_CTRL_MODE_HI:`DSG_CTRL_MODE_LO];
  wire [1:0] new_mode = wv_ctrl[`DSG_CTRL_MODE_HI:`DSG_CTRL_MODE_LO];
  // mode 3 is out of range under vector control, so such a write keeps the old mode, or the default if the old one was 3
  wire mode_ok = !(wv_ctrl[`DSG_CTRL_VEC] && new_mode == dsg_pkg::dsg_m_brake);
  // an old mode 3 must not survive a switch to vector control
  wire [1:0] kept_mode = (sel_mode == dsg_pkg::dsg_m_brake) ? `DSG_MODE_RST : sel_mode;
  // vector control runs its own regulation, selection falls back to default
  wire [1:0] eff_mode = vec_ctrl ? `DSG_MODE_RST : sel_mode;

  wire [10:0] stall_lvl = f_stall_lvl(hv_class, vin_q);
  wire [10:0] ov_lvl = hv_class ? OV_LVL_HI : OV_LVL_LO;
  wire near = bus_s_q >= stall_lvl;
  wire ov_trip = bus_s_q >= ov_lvl;
  wire guard = eff_mode != dsg_pkg::dsg_m_off;
  wire [15:0] min_per_raw = dtime_q / `DSG_ADAPT_DIV;
  wire [15:0] min_per = (min_per_raw == 16'h0) ? 16'h1 : min_per_raw;
  wire ramp_en = st_q == dsg_pkg::dsg_st_ramp && !fault_q;
  wire step;

  dsg_ramp #(
    .PW(16)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(!active),
    .en(ramp_en),
    .period(per_q),
    .step(step)
  );

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      dsg_pkg::dsg_st_idle: begin
        if (run && freq_q != 16'h0) begin
          st_d = dsg_pkg::dsg_st_ramp;
        end
      end
      dsg_pkg::dsg_st_ramp: begin
        if (!run) begin
          st_d = dsg_pkg::dsg_st_idle;
        end else if (freq_q == 16'h0) begin
          st_d = dsg_pkg::dsg_st_done;
        end else if (guard && near) begin
          st_d = dsg_pkg::dsg_st_pause;
        end
      end
      dsg_pkg::dsg_st_pause: begin
        // compared every cycle, so release follows the bus at once
        if (!run) begin
          st_d = dsg_pkg::dsg_st_idle;
        end else if (!guard || !near) begin
          st_d = dsg_pkg::dsg_st_ramp;
        end
      end
      dsg_pkg::dsg_st_done: begin
        if (!run) begin
          st_d = dsg_pkg::dsg_st_idle;
        end
      end
      default: st_d = dsg_pkg::dsg_st_idle;
    endcase
  end

  wire ev_stall = st_q == dsg_pkg::dsg_st_ramp && st_d == dsg_pkg::dsg_st_pause;
  // a stop write clears the fault; run gating keeps it from tripping again on the way out
  wire ev_ov = active && run && ov_trip && !fault_q;
  wire fault_clr = wr_ctrl && !wv_ctrl[`DSG_CTRL_RUN];
  wire ev_done = st_q == dsg_pkg::dsg_st_ramp && st_d == dsg_pkg::dsg_st_done;
  wire [2:0] sts_set = {ev_done, ev_ov, ev_stall};
  wire [31:0] live = {11'h0, stall_lvl, 3'h0, fault_q, eff_mode, st_q};

  logic [31:0] rd_mux;
  always_comb begin
    unique case (araddr)
      `DSG_OFF_CTRL: rd_mux = {27'h0, ctrl_q};
      `DSG_OFF_VIN: rd_mux = {21'h0, vin_q};
      `DSG_OFF_DTIME: rd_mux = {16'h0, dtime_q};
      `DSG_OFF_FREQ: rd_mux = {16'h0, freq_q};
      `DSG_OFF_STS: rd_mux = {29'h0, sts_q};
      `DSG_OFF_MASK: rd_mux = {29'h0, mask_q};
      `DSG_OFF_LIVE: rd_mux = live;
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_ok = araddr == `DSG_OFF_CTRL || araddr == `DSG_OFF_VIN ||
               araddr == `DSG_OFF_DTIME || araddr == `DSG_OFF_FREQ ||
               araddr == `DSG_OFF_STS || araddr == `DSG_OFF_MASK ||
               araddr == `DSG_OFF_LIVE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `DSG_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        waddr_q <= awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `DSG_RESP_OKAY : `DSG_RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `DSG_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? `DSG_RESP_OKAY : `DSG_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // bus voltage must move slowly against aclk; bits are synchronised one by one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_m_q <= 11'h0;
      bus_s_q <= 11'h0;
    end else begin
      bus_m_q <= bus_volt;
      bus_s_q <= bus_m_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= {2'h0, `DSG_MODE_RST, 1'b0};
      vin_q <= `DSG_VIN_RST;
      dtime_q <= DTIME_RST;
      mask_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[`DSG_CTRL_RUN] <= wv_ctrl[`DSG_CTRL_RUN];
        if (!active) begin
          ctrl_q[`DSG_CTRL_HV] <= wv_ctrl[`DSG_CTRL_HV];
          ctrl_q[`DSG_CTRL_VEC] <= wv_ctrl[`DSG_CTRL_VEC];
          ctrl_q[`DSG_CTRL_MODE_HI:`DSG_CTRL_MODE_LO] <= mode_ok ? new_mode : kept_mode;
        end
      end
      if (wr_vin && !active) begin
        vin_q <= wv_vin[10:0];
      end
      if (wr_dtime && !active) begin
        dtime_q <= (wv_dtime[15:0] == 16'h0) ? 16'h1 : wv_dtime[15:0];
      end
      if (wr_mask) begin
        mask_q <= wv_mask[2:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= dsg_pkg::dsg_st_idle;
      freq_q <= 16'h0;
      per_q <= 16'h1;
    end else begin
      st_q <= st_d;
      if (wr_freq && !active) begin
        freq_q <= wv_freq[15:0];
      end else if (step && freq_q != 16'h0) begin
        freq_q <= freq_q - 16'h1;
      end
      if (!active || eff_mode != dsg_pkg::dsg_m_intel || st_q == dsg_pkg::dsg_st_pause) begin
        per_q <= dtime_q;
      end else if (step && per_q > min_per) begin
        per_q <= per_q - 16'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      brake_q <= 1'b0;
      sts_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      if (ev_ov) begin
        fault_q <= 1'b1;
      end else if (fault_clr) begin
        fault_q <= 1'b0;
      end
      brake_q <= active && eff_mode == dsg_pkg::dsg_m_brake && near;
      // set wins over the read clear
      sts_q <= rd_sts ? sts_set : (sts_q | sts_set);
      irq_q <= |(sts_q & mask_q);
    end
  end

  assign out_freq = freq_q;
  assign ramp_paused = st_q == dsg_pkg::dsg_st_pause;
  assign brake_en = brake_q;
  assign bus_overvoltage_fault = fault_q;
  assign irq = irq_q;

  sequence s_pause_gen;
    st_q == dsg_pkg::dsg_st_pause && eff_mode == dsg_pkg::dsg_m_gen;
  endsequence
  sequence s_back_ramp;
    st_q == dsg_pkg::dsg_st_ramp;
  endsequence

  property p_pause_near;
    @(posedge aclk) disable iff (!aresetn)
    st_q == dsg_pkg::dsg_st_ramp && run && freq_q != 16'h0 && guard && near
      |=> st_q == dsg_pkg::dsg_st_pause;
  endproperty
  a_pause_near: assert property (p_pause_near) else $error("no pause at stall level");
  property p_resume;
    @(posedge aclk) disable iff (!aresetn)
    st_q == dsg_pkg::dsg_st_pause && run && !near |=> st_q == dsg_pkg::dsg_st_ramp;
  endproperty
  a_resume: assert property (p_resume) else $error("ramp not resumed");
  property p_gen_rate;
    @(posedge aclk) disable iff (!aresetn)
    s_pause_gen ##1 s_back_ramp |-> per_q == $past(dtime_q);
  endproperty
  a_gen_rate: assert property (p_gen_rate) else $error("mode 1 rate changed");
  property p_adapt_bound;
    @(posedge aclk) disable iff (!aresetn)
    active && eff_mode == dsg_pkg::dsg_m_intel ##1 active |-> per_q >= min_per && per_q <= dtime_q;
  endproperty
  a_adapt_bound: assert property (p_adapt_bound) else $error("adapted period out of range");
  property p_off_no_pause;
    @(posedge aclk) disable iff (!aresetn)
    st_q == dsg_pkg::dsg_st_ramp && eff_mode == dsg_pkg::dsg_m_off |=> !ramp_paused;
  endproperty
  a_off_no_pause: assert property (p_off_no_pause) else $error("mode 0 paused");
  property p_ov_fault;
    @(posedge aclk) disable iff (!aresetn)
    active && run && ov_trip && !fault_clr |=> bus_overvoltage_fault;
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("overvoltage fault missed");
  property p_lvl_lo;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ramp_paused) && !hv_class |-> $past(bus_s_q) >= 11'h17c;
  endproperty
  a_lvl_lo: assert property (p_lvl_lo) else $error("low class paused below 380 V");
  property p_lvl_hi;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ramp_paused) && hv_class |->
      $past(bus_s_q) >= ((vin_q >= 11'h190) ? 11'h2f8 : 11'h294);
  endproperty
  a_lvl_hi: assert property (p_lvl_hi) else $error("high class level wrong");
  property p_brake;
    @(posedge aclk) disable iff (!aresetn)
    active && eff_mode == dsg_pkg::dsg_m_brake && near |=> brake_en;
  endproperty
  a_brake: assert property (p_brake) else $error("braking not applied");
  property p_vec_range;
    @(posedge aclk) disable iff (!aresetn)
    vec_ctrl |-> sel_mode != dsg_pkg::dsg_m_brake && eff_mode == dsg_pkg::dsg_m_gen;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector mode selection used");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    ramp_paused |=> out_freq == $past(out_freq);
  endproperty
  a_hold: assert property (p_hold) else $error("frequency moved while paused");
endmodule

//--- dsg_regs.svh
// Function
// - modes 1,2 pause ramp near stall level
// - mode 1 resumes at configured deceleration rate
// - mode 2 adapts, bounded by time/10
// - mode 0 no intervention; overvoltage raises fault
// - stall level 380 V or 760 V
// - high class: 760 V, 660 V below 400 V
// - mode 3 stall prevention with dynamic braking
// - mode codes 0-3, default 1; vector 0-2
// - vector control ignores deceleration stall mode
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH
`define DSG_OFF_CTRL 8'h00
`define DSG_OFF_VIN 8'h04
`define DSG_OFF_DTIME 8'h08
`define DSG_OFF_FREQ 8'h0c
`define DSG_OFF_STS 8'h10
`define DSG_OFF_MASK 8'h14
`define DSG_OFF_LIVE 8'h18
`define DSG_CTRL_RUN 0
`define DSG_CTRL_MODE_LO 1
`define DSG_CTRL_MODE_HI 2
`define DSG_CTRL_HV 3
`define DSG_CTRL_VEC 4
`define DSG_STS_STALL 0
`define DSG_STS_OV 1
`define DSG_STS_DONE 2
`define DSG_MODE_RST 2'h1
`define DSG_LVL_LO 11'h17c
`define DSG_LVL_HI 11'h2f8
`define DSG_LVL_HI_RED 11'h294
`define DSG_VIN_SPLIT 11'h190
`define DSG_VIN_RST 11'h190
`define DSG_ADAPT_DIV 16'h000a
`define DSG_RESP_OKAY 2'h0
`define DSG_RESP_SLVERR 2'h2
`endif

//--- dsg_pkg.sv
package dsg_pkg;
  typedef enum logic [3:0] {
    dsg_st_idle = 4'b0001,
    dsg_st_ramp = 4'b0010,
    dsg_st_pause = 4'b0100,
    dsg_st_done = 4'b1000
  } dsg_state_t;
  typedef enum logic [1:0] {
    dsg_m_off = 2'h0,
    dsg_m_gen = 2'h1,
    dsg_m_intel = 2'h2,
    dsg_m_brake = 2'h3
  } dsg_mode_t;
endpackage

//--- dsg_ramp.sv
`timescale 1ns/1ps
module dsg_ramp #(
  parameter int PW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic en,
  input wire logic [PW-1:0] period,
  output logic step
);
  logic [PW-1:0] cnt_q;
  // count is kept while paused so the step phase survives a stall
  assign step = en && (cnt_q >= period - {{(PW-1){1'b0}}, 1'b1});

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt_q <= '0;
    end else if (step) begin
      cnt_q <= '0;
    end else if (en) begin
      cnt_q <= cnt_q + {{(PW-1){1'b0}}, 1'b1};
    end
  end
endmodule

//--- dsg_bus_model.sv
`timescale 1ns/1ps
module dsg_bus_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [10:0] set_volt,
  output logic [10:0] bus_volt
);
  // sensor lags the set point by one edge, so the guard never sees a step early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_volt <= 11'h12c;
    end else begin
      bus_volt <= set_volt;
    end
  end
endmodule

//--- decel_overvoltage_stall_guard_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module decel_overvoltage_stall_guard_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [10:0] set_volt = 11'h12c;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [10:0] bus_volt;
  logic [15:0] out_freq, f, f_lim;
  logic ramp_paused, brake_en, bus_overvoltage_fault, irq;
  int checked = 0;
  int n_errors = 0;
  int p;
  logic hv [3] = '{1'b0, 1'b1, 1'b1};
  logic [10:0] vin [3] = '{11'h190, 11'h190, 11'h18f};
  logic [10:0] lvl [3] = '{11'h17c, 11'h2f8, 11'h294};

  always #12.5 aclk = ~aclk;

  dsg_bus_model bus (.aclk(aclk), .aresetn(aresetn), .set_volt(set_volt), .bus_volt(bus_volt));

  dsg_top #(.OV_LVL_LO(11'h19a), .OV_LVL_HI(11'h334), .DTIME_RST(16'h03e8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bus_volt(bus_volt), .out_freq(out_freq), .ramp_paused(ramp_paused),
    .brake_en(brake_en), .bus_overvoltage_fault(bus_overvoltage_fault), .irq(irq));

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic timed_out;
    n_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    stop_test;
  endtask

  // leading edge keeps a new request from landing in the step that dropped ready
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (!bvalid) timed_out();
    `CHK(bresp, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (!rvalid) timed_out();
    v = rdata;
    `CHK(rresp, er)
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = ramp_paused;
      1: pick = brake_en;
      2: pick = bus_overvoltage_fault;
      3: pick = irq;
      default: pick = (out_freq <= f_lim);
    endcase
  endfunction

  task automatic wait_for(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 1000) timed_out();
  endtask

  // cycles between two successive frequency steps
  task automatic measure(output int q);
    f = out_freq;
    q = 0;
    while (out_freq === f && q < 1000) begin
      @(posedge aclk);
      q++;
    end
    f = out_freq;
    q = 0;
    while (out_freq === f && q < 1000) begin
      @(posedge aclk);
      q++;
    end
  endtask

  task automatic start(input logic [31:0] c, input logic [15:0] t, input logic [15:0] fr);
    set_volt <= 11'h12c;
    wr(8'h00, c, 2'h0);
    wr(8'h08, {16'h0, t}, 2'h0);
    wr(8'h0c, {16'h0, fr}, 2'h0);
    wr(8'h00, c | 32'h1, 2'h0);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 2'h0, d); `CHK(d, 32'h2)
    rd(8'h04, 2'h0, d); `CHK(d, 32'h190)
    rd(8'h08, 2'h0, d); `CHK(d, 32'h3e8)
    rd(8'h18, 2'h0, d); `CHK(d, 32'h5f011)
    rd(8'h1c, 2'h2, d); `CHK(d, 32'h0)
    wr(8'h1c, 32'h1, 2'h2);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {28'h0, hv[i], 3'h2}, 2'h0);
      wr(8'h04, {21'h0, vin[i]}, 2'h0);
      rd(8'h18, 2'h0, d); `CHK(d[20:10], lvl[i])
    end
    $display("test reset and levels done");
    start(32'h2, 16'h2, 16'h28);
    measure(p); `CHK(p, 2)
    set_volt <= 11'h17c;
    wait_for(0, 1'b1); `CHK(ramp_paused, 1'b1)
    f = out_freq;
    repeat (10) @(posedge aclk);
    `CHK(out_freq, f)
    `CHK(irq, 1'b0)
    set_volt <= 11'h17b;
    wait_for(0, 1'b0); `CHK(ramp_paused, 1'b0)
    measure(p); `CHK(p, 2)
    f_lim = 16'h0;
    wait_for(4, 1'b1);
    rd(8'h10, 2'h0, d); `CHK(d, 32'h5)
    wr(8'h00, 32'h0, 2'h0);
    $display("test mode 1 done");
    start(32'h4, 16'h14, 16'h64);
    f_lim = 16'h46;
    wait_for(4, 1'b1);
    measure(p); `CHK(p, 2)
    wr(8'h00, 32'h0, 2'h0);
    $display("test mode 2 done");
    rd(8'h10, 2'h0, d);
    wr(8'h14, 32'h2, 2'h0);
    start(32'h0, 16'h2, 16'h28);
    set_volt <= 11'h190;
    repeat (20) begin @(posedge aclk); `CHK(ramp_paused, 1'b0) end
    `CHK(out_freq < 16'h24, 1'b1)
    set_volt <= 11'h1a4;
    wait_for(2, 1'b1); `CHK(bus_overvoltage_fault, 1'b1)
    wait_for(3, 1'b1); `CHK(irq, 1'b1)
    rd(8'h10, 2'h0, d); `CHK(d[1], 1'b1)
    wait_for(3, 1'b0); `CHK(irq, 1'b0)
    wr(8'h14, 32'h0, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    wait_for(2, 1'b0); `CHK(bus_overvoltage_fault, 1'b0)
    $display("test mode 0 done");
    start(32'h6, 16'h2, 16'h28);
    set_volt <= 11'h17c;
    wait_for(1, 1'b1);
    wait_for(0, 1'b1); `CHK(brake_en, 1'b1)
    set_volt <= 11'h12c;
    wait_for(0, 1'b0);
    wait_for(1, 1'b0); `CHK(ramp_paused, 1'b0)
    wr(8'h00, 32'h0, 2'h0);
    $display("test mode 3 done");
    // mode 3 is still held from the previous run
    wr(8'h00, 32'h16, 2'h0);
    rd(8'h00, 2'h0, d); `CHK(d, 32'h12)
    wr(8'h00, 32'h10, 2'h0);
    rd(8'h18, 2'h0, d); `CHK(d[5:4], 2'h1)
    wr(8'h00, 32'h16, 2'h0);
    rd(8'h00, 2'h0, d); `CHK(d[2:1], 2'h0)
    start(32'h18, 16'h2, 16'h28);
    set_volt <= 11'h294;
    wait_for(0, 1'b1); `CHK(ramp_paused, 1'b1)
    wr(8'h00, 32'h0, 2'h0);
    $display("test vector control done");
    stop_test;
  end
endmodule
